// File: rtl/cycle_request_control.v
`timescale 1ns/100ps
`include "cycle_request_regs.vh"

// Operation
// - Short at start-up: finish handshake, then stop requesting cycles.
// - Suppression lasts the skip timeout; primary then adds its off period.
// - In normal operation a deglitched short stops requests.
// - After a detected short the secondary gives up control.
// - Low-output level held past its timeout gives up control.
// - Cable drop compensation only for 5 V with divider to ground.
// - Rectifier gate on only for requested cycles after a winding falling edge.
// - Rectifier gate held off while current sense exceeds three times threshold.
// - Primary switches on at cycle start, off at limit or max duty.
// - A started switching cycle always completes.
// - Clock runs always; comparator decides switch or skip each cycle.
// - Current limit state follows history of switch and skip decisions.
// - Four current limit states, each with its own level.
// - Gate off before next request in CCM, at threshold in DCM.
// - Above current threshold pulses are adjusted to hold current fixed.
// - Below current threshold requests regulate feedback to reference.
// - Constant current held above 2.5 V; below, auto-restart.
// - With no requests past skip timeout primary enters auto-restart.
// - Three missed answers or three unrequested cycles restart handshake.
module cycle_request_control #(
  parameter LOW_OUTPUT_TIMEOUT_CYC = `LOW_OUTPUT_TIMEOUT_CYC,
  parameter REQUEST_SKIP_TIMEOUT_CYC = `REQUEST_SKIP_TIMEOUT_CYC,
  parameter HISTORY_BITS = `HISTORY_BITS
) (
  input wire ref_clk,
  input wire rst,
  input wire fb_below_reference,
  input wire fb_below_short_threshold,
  input wire fb_below_low_output_threshold,
  input wire current_above_threshold,
  input wire current_above_surge,
  input wire winding_falling,
  input wire rectifier_above_turnoff,
  input wire output_below_cc_floor,
  input wire primary_switched,
  input wire primary_cycle_done,
  input wire divider_to_ground,
  input wire output_is_5v,
  output reg cycle_request,
  output reg rectifier_gate,
  output reg [1:0] current_limit_level,
  output reg secondary_in_control,
  output reg constant_current_mode,
  output reg cable_drop_compensation,
  output reg auto_restart
);

  localparam ST_HANDSHAKE = 4'b0001;
  localparam ST_CONTROL = 4'b0010;
  localparam ST_SUPPRESS = 4'b0100;
  localparam ST_RELEASED = 4'b1000;

  localparam LIM_HIGH = 4'b0001;
  localparam LIM_MED = 4'b0010;
  localparam LIM_LOW = 4'b0100;
  localparam LIM_MIN = 4'b1000;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  wire [10:0] sync_bus;
  input_sync #(
    .WIDTH(11)
  ) sync_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({fb_below_reference, fb_below_short_threshold, fb_below_low_output_threshold,
      current_above_threshold, current_above_surge, winding_falling,
      rectifier_above_turnoff, output_below_cc_floor, primary_switched,
      primary_cycle_done, 1'b0}),
    .sync_out(sync_bus)
  );

  wire fb_low = sync_bus[10];
  wire fb_short_raw = sync_bus[9];
  wire fb_low_out = sync_bus[8];
  wire cur_over = sync_bus[7];
  wire surge = sync_bus[6];
  wire wind_edge = sync_bus[5];
  wire gate_off_thr = sync_bus[4];
  wire below_floor = sync_bus[3];
  wire pri_sw = sync_bus[2];
  wire pri_done = sync_bus[1];

  // ----------------------------------------------------------------
  // Switching period tick
  // ----------------------------------------------------------------
  localparam integer PERIOD_CYC = `SWITCH_PERIOD_CYC;
  localparam [15:0] PERIOD_LAST = PERIOD_CYC[15:0] - 16'h0001;
  reg [15:0] period_reg;
  wire period_tick = (period_reg == 16'h0000);

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      period_reg <= 16'h0000;
    else if (period_tick)
      period_reg <= PERIOD_LAST;
    else
      period_reg <= period_reg - 16'h0001;
  end

  // ----------------------------------------------------------------
  // Deglitch of the short comparator and low-output timer
  // ----------------------------------------------------------------
  reg [9:0] short_cnt_reg;
  reg fb_short_reg;
  reg [31:0] low_cnt_reg;
  reg low_timeout_reg;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      short_cnt_reg <= 10'h000;
      fb_short_reg <= 1'b0;
      low_cnt_reg <= 32'h00000000;
      low_timeout_reg <= 1'b0;
    end
    else
    begin
      if (!fb_short_raw)
      begin
        short_cnt_reg <= 10'h000;
        fb_short_reg <= 1'b0;
      end
      else if (short_cnt_reg == `SHORT_DEGLITCH_CYC - 1)
        fb_short_reg <= 1'b1;
      else
        short_cnt_reg <= short_cnt_reg + 10'h001;
      if (!fb_low_out)
      begin
        low_cnt_reg <= 32'h00000000;
        low_timeout_reg <= 1'b0;
      end
      else if (low_cnt_reg == LOW_OUTPUT_TIMEOUT_CYC - 1)
        low_timeout_reg <= 1'b1;
      else
        low_cnt_reg <= low_cnt_reg + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Control state machine and cycle decision
  // ----------------------------------------------------------------
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [31:0] skip_cnt_reg;
  reg [1:0] hs_cnt_reg;
  reg hs_seen_reg;
  reg [1:0] miss_cnt_reg;
  reg [1:0] extra_cnt_reg;
  reg short_at_start_reg;
  reg awaiting_reg;
  reg in_cycle_reg;
  reg requested_cycle_reg;
  reg [HISTORY_BITS-1:0] history_reg;

  wire want_cycle = fb_low && !cur_over && !in_cycle_reg;
  wire fault = fb_short_reg || low_timeout_reg || (cur_over && below_floor);
  wire rehandshake = (miss_cnt_reg == `HANDSHAKE_FAULT_COUNT - 1 && awaiting_reg && period_tick)
    || (extra_cnt_reg == `HANDSHAKE_FAULT_COUNT - 1 && pri_sw && !awaiting_reg);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_HANDSHAKE:
        if (period_tick && hs_cnt_reg == `HANDSHAKE_PULSES - 1 && hs_seen_reg)
          state_next = (fb_short_raw || short_at_start_reg) ? ST_SUPPRESS : ST_CONTROL;
      ST_CONTROL:
        if (fault)
          state_next = ST_SUPPRESS;
        else if (rehandshake)
          state_next = ST_HANDSHAKE;
      ST_SUPPRESS:
        if (skip_cnt_reg == REQUEST_SKIP_TIMEOUT_CYC - 1)
          state_next = ST_RELEASED;
      ST_RELEASED:
        if (!fault && !fb_short_raw)
          state_next = ST_HANDSHAKE;
      default:
        state_next = ST_HANDSHAKE;
    endcase
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_HANDSHAKE;
      skip_cnt_reg <= 32'h00000000;
      hs_cnt_reg <= 2'h0;
      hs_seen_reg <= 1'b0;
      miss_cnt_reg <= 2'h0;
      extra_cnt_reg <= 2'h0;
      short_at_start_reg <= 1'b0;
      awaiting_reg <= 1'b0;
      in_cycle_reg <= 1'b0;
      requested_cycle_reg <= 1'b0;
      history_reg <= {HISTORY_BITS{1'b0}};
      cycle_request <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cycle_request <= 1'b0;
      skip_cnt_reg <= (state_reg == ST_SUPPRESS) ? skip_cnt_reg + 32'h00000001 : 32'h00000000;
      if (state_reg == ST_HANDSHAKE && fb_short_raw)
        short_at_start_reg <= 1'b1;
      else if (state_reg == ST_CONTROL)
        short_at_start_reg <= 1'b0;
      if (pri_sw)
        in_cycle_reg <= 1'b1;
      else if (pri_done)
        in_cycle_reg <= 1'b0;
      // The primary answers a few clocks after the request, long before the next tick,
      // so the answer is held here until the tick that counts it.
      if (period_tick)
        hs_seen_reg <= pri_sw;
      else if (pri_sw)
        hs_seen_reg <= 1'b1;
      // A fresh handshake forgets an earlier start-up short so that it can end in control.
      if (state_next == ST_HANDSHAKE && state_reg != ST_HANDSHAKE)
      begin
        hs_cnt_reg <= 2'h0;
        hs_seen_reg <= 1'b0;
        short_at_start_reg <= 1'b0;
      end
      if (period_tick)
      begin
        if (state_reg == ST_HANDSHAKE)
        begin
          cycle_request <= 1'b1;
          awaiting_reg <= 1'b1;
          if (hs_seen_reg && hs_cnt_reg != `HANDSHAKE_PULSES - 1)
            hs_cnt_reg <= hs_cnt_reg + 2'h1;
        end
        else if (state_reg == ST_CONTROL && !fault)
        begin
          cycle_request <= want_cycle;
          history_reg <= {history_reg[HISTORY_BITS-2:0], want_cycle};
          requested_cycle_reg <= want_cycle;
          awaiting_reg <= want_cycle;
          if (awaiting_reg && !pri_sw)
            miss_cnt_reg <= (miss_cnt_reg == 2'h3) ? 2'h3 : miss_cnt_reg + 2'h1;
          else
            miss_cnt_reg <= 2'h0;
        end
        else
          requested_cycle_reg <= 1'b0;
      end
      if (pri_sw && state_reg == ST_CONTROL)
      begin
        if (!awaiting_reg)
          extra_cnt_reg <= (extra_cnt_reg == 2'h3) ? 2'h3 : extra_cnt_reg + 2'h1;
        else
          extra_cnt_reg <= 2'h0;
        awaiting_reg <= 1'b0;
        miss_cnt_reg <= 2'h0;
      end
      if (rehandshake)
      begin
        miss_cnt_reg <= 2'h0;
        extra_cnt_reg <= 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Current limit state machine
  // ----------------------------------------------------------------
  reg [3:0] lim_reg;
  reg [3:0] lim_next;
  reg [3:0] ones;
  integer k;

  always @*
  begin
    ones = 4'h0;
    for (k = 0; k < HISTORY_BITS; k = k + 1)
      ones = ones + {3'h0, history_reg[k]};
    if (ones >= 4'h6)
      lim_next = LIM_HIGH;
    else if (ones >= 4'h4)
      lim_next = LIM_MED;
    else if (ones >= 4'h2)
      lim_next = LIM_LOW;
    else
      lim_next = LIM_MIN;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lim_reg <= LIM_HIGH;
      current_limit_level <= `LIMIT_LEVEL_3;
    end
    else
    begin
      // History moves only at ticks, so the limit follows the decision just taken.
      lim_reg <= lim_next;
      case (lim_reg)
        LIM_HIGH: current_limit_level <= `LIMIT_LEVEL_3;
        LIM_MED: current_limit_level <= `LIMIT_LEVEL_2;
        LIM_LOW: current_limit_level <= `LIMIT_LEVEL_1;
        LIM_MIN: current_limit_level <= `LIMIT_LEVEL_0;
        default: current_limit_level <= `LIMIT_LEVEL_3;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Rectifier gate and status outputs
  // ----------------------------------------------------------------
  wire next_request = period_tick && ((state_reg == ST_HANDSHAKE)
    || (state_reg == ST_CONTROL && want_cycle && !fault));

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rectifier_gate <= 1'b0;
      secondary_in_control <= 1'b0;
      constant_current_mode <= 1'b0;
      cable_drop_compensation <= 1'b0;
      auto_restart <= 1'b0;
    end
    else
    begin
      if (surge)
        rectifier_gate <= 1'b0;
      else if (next_request || gate_off_thr)
        rectifier_gate <= 1'b0;
      else if (requested_cycle_reg && wind_edge)
        rectifier_gate <= 1'b1;
      secondary_in_control <= (state_reg == ST_CONTROL);
      constant_current_mode <= cur_over;
      cable_drop_compensation <= output_is_5v && divider_to_ground;
      auto_restart <= (state_reg == ST_SUPPRESS) || (state_reg == ST_RELEASED);
    end
  end

endmodule

// File: rtl/cycle_request_regs.vh
`ifndef CYCLE_REQUEST_REGS_VH
`define CYCLE_REQUEST_REGS_VH

// Clock rate in kHz and derived figures.
`define CLK_KHZ 100000
// Deglitch on the short comparator, in microseconds (least figure, shorter than 10 us).
`define SHORT_DEGLITCH_US 8
`define SHORT_DEGLITCH_CYC ((`SHORT_DEGLITCH_US * `CLK_KHZ) / 1000)
// Switching period of the internal clock, in nanoseconds.
`define SWITCH_PERIOD_NS 10000
`define SWITCH_PERIOD_CYC ((`SWITCH_PERIOD_NS * (`CLK_KHZ / 1000)) / 1000)
// Low-output timeout and request skip timeout, in microseconds.
`define LOW_OUTPUT_TIMEOUT_US 64000
`define LOW_OUTPUT_TIMEOUT_CYC ((`LOW_OUTPUT_TIMEOUT_US * `CLK_KHZ) / 1000)
`define REQUEST_SKIP_TIMEOUT_US 82000
`define REQUEST_SKIP_TIMEOUT_CYC ((`REQUEST_SKIP_TIMEOUT_US * `CLK_KHZ) / 1000)
// Missed answers or unrequested cycles that force a new handshake.
`define HANDSHAKE_FAULT_COUNT 3
// Handshake request pulses that must be answered at start-up.
`define HANDSHAKE_PULSES 2
// Width of the per-cycle decision history.
`define HISTORY_BITS 8
// Current limit levels, one per state.
`define LIMIT_LEVEL_0 2'h0
`define LIMIT_LEVEL_1 2'h1
`define LIMIT_LEVEL_2 2'h2
`define LIMIT_LEVEL_3 2'h3

`endif

// File: rtl/input_sync.v
`timescale 1ns/100ps

// Two flip-flop synchroniser, one generate stage per bit.
module input_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] first_reg;
  reg [WIDTH-1:0] second_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bit_stage
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          first_reg[i] <= 1'b0;
          second_reg[i] <= 1'b0;
        end
        else
        begin
          first_reg[i] <= async_in[i];
          second_reg[i] <= first_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = second_reg;

endmodule

// File: verif/cycle_request_assertions.sv
`timescale 1ns/100ps
module cycle_request_checker #(
  parameter LOW_OUTPUT_TIMEOUT_CYC = 50
) (
  input wire ref_clk,
  input wire rst,
  input wire fb_below_short_threshold,
  input wire fb_below_low_output_threshold,
  input wire current_above_surge,
  input wire output_is_5v,
  input wire cycle_request,
  input wire rectifier_gate,
  input wire secondary_in_control,
  input wire cable_drop_compensation
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  reg [15:0] short_cnt_reg;
  reg [31:0] low_cnt_reg;
  reg [15:0] since_req_reg;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      short_cnt_reg <= 16'h0;
      low_cnt_reg <= 32'h0;
      since_req_reg <= 16'hFFFF;
    end
    else
    begin
      short_cnt_reg <= !fb_below_short_threshold ? 16'h0 :
        (short_cnt_reg < 16'h1770 ? short_cnt_reg + 16'h1 : short_cnt_reg);
      low_cnt_reg <= fb_below_low_output_threshold ? low_cnt_reg + 32'h1 : 32'h0;
      since_req_reg <= cycle_request ? 16'h0 :
        (since_req_reg != 16'hFFFF ? since_req_reg + 16'h1 : since_req_reg);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_surge_held;
    current_above_surge [*4];
  endsequence
  sequence s_strap_high_v;
    !output_is_5v [*4];
  endsequence
  AST_REQ_SINGLE: assert property (cycle_request |=> !cycle_request [*8])
    else $error("cycle request longer than one cycle or too close");
  AST_GATE_OFF_AT_REQ: assert property (cycle_request |=> !rectifier_gate)
    else $error("gate still on after a cycle request");
  AST_GATE_NEEDS_REQ: assert property ($rose(rectifier_gate) |-> since_req_reg < 16'h03E8)
    else $error("gate on without a recent cycle request");
  AST_SURGE_GATE: assert property (s_surge_held |=> !rectifier_gate)
    else $error("gate on during surge current");
  AST_COMP_OFF: assert property (s_strap_high_v |=> !cable_drop_compensation)
    else $error("compensation on for a non 5 V design");
  AST_SHORT_STOP: assert property (short_cnt_reg >= 16'h03E8 |-> !cycle_request)
    else $error("cycle request while feedback is shorted");
  AST_SHORT_RELEASE: assert property (short_cnt_reg >= 16'h03E8 |-> !secondary_in_control)
    else $error("control kept while feedback is shorted");
  AST_LOW_RELEASE: assert property
    (low_cnt_reg > LOW_OUTPUT_TIMEOUT_CYC + 8 |-> !secondary_in_control)
    else $error("control kept after low output timeout");
endmodule
bind cycle_request_control cycle_request_checker #(
  .LOW_OUTPUT_TIMEOUT_CYC(LOW_OUTPUT_TIMEOUT_CYC)
) cycle_request_checker_inst (.ref_clk, .rst, .fb_below_short_threshold,
  .fb_below_low_output_threshold, .current_above_surge, .output_is_5v, .cycle_request,
  .rectifier_gate, .secondary_in_control, .cable_drop_compensation);

// File: verif/cycle_request_control_tb.sv
`timescale 1ns/100ps
module cycle_request_control_tb;
  reg ref_clk, rst, fb_ref, fb_short, fb_low, cur_thr, cur_surge, turn_off;
  reg floor_low, div_gnd, is_5v, silent;
  wire cyc_req, gate, in_ctl, cur_mode, comp, restart, sw, done, wf;
  wire [1:0] lim;
  integer n_mismatch, check_count, seed, i, k;
  reg [7:0] pat;
  cycle_request_control #(.LOW_OUTPUT_TIMEOUT_CYC(50), .REQUEST_SKIP_TIMEOUT_CYC(80))
  cycle_request_control_inst (.ref_clk(ref_clk), .rst(rst), .fb_below_reference(fb_ref),
    .fb_below_short_threshold(fb_short), .fb_below_low_output_threshold(fb_low),
    .current_above_threshold(cur_thr), .current_above_surge(cur_surge),
    .winding_falling(wf), .rectifier_above_turnoff(turn_off), .output_below_cc_floor(floor_low),
    .primary_switched(sw), .primary_cycle_done(done), .divider_to_ground(div_gnd),
    .output_is_5v(is_5v), .cycle_request(cyc_req), .rectifier_gate(gate),
    .current_limit_level(lim), .secondary_in_control(in_ctl), .constant_current_mode(cur_mode),
    .cable_drop_compensation(comp), .auto_restart(restart));
  primary_switch_model primary_switch_model_inst (.ref_clk(ref_clk), .cycle_request(cyc_req),
    .silent(silent), .primary_switched(sw), .primary_cycle_done(done), .winding_falling(wf));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Checking and waiting
  // ----------------------------------------
  task print_verdict;
    begin
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task check(input [7:0] seen, input [7:0] exp, input string what);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Waits for request (0), gate (1) or control (2) within lim cycles.
  task wait_for(input integer sel, input integer lim_cyc);
    integer t;
    begin
      t = 0;
      while (!(sel == 0 ? cyc_req === 1'b1 : sel == 1 ? gate === 1'b1 : in_ctl === 1'b1)
        && t < lim_cyc)
      begin
        @(negedge ref_clk);
        t = t + 1;
      end
      if (t >= lim_cyc)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error wait %0d expected event seen none", sel);
        print_verdict;
      end
    end
  endtask
  function [1:0] exp_level(input [7:0] p);
    integer j, ones;
    begin
      ones = 0;
      for (j = 0; j < 8; j = j + 1)
        ones = ones + p[j];
      exp_level = ones >= 6 ? 2'h3 : ones >= 4 ? 2'h2 : ones >= 2 ? 2'h1 : 2'h0;
    end
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    seed = 32'h8c3a;
    {rst, fb_ref, div_gnd, is_5v} = 4'hF;
    {fb_short, fb_low, cur_thr, cur_surge, turn_off, floor_low, silent} = 7'h00;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    check(lim, 2'h3, "reset limit");
    check({in_ctl, cyc_req, gate, restart}, 8'h00, "reset outputs");
    rst = 1'b0;
    wait_for(2, 10000);
    for (k = 0; k < 6; k = k + 1)
    begin
      pat = k < 4 ? 32'h01033F1F >> (8 * k) : $random(seed);
      fb_ref = 1'b1;
      wait_for(0, 3000);
      for (i = 0; i < 8; i = i + 1)
      begin
        cyc(500);
        fb_ref = pat[i];
        cyc(500);
      end
      cyc(3);
      check(lim, exp_level(pat), "limit level");
    end
    fb_ref = 1'b1;
    wait_for(0, 3000);
    wait_for(1, 60);
    check(gate, 1'b1, "gate on");
    wait_for(0, 3000);
    cyc(1);
    check(gate, 1'b0, "gate off ccm");
    wait_for(1, 60);
    turn_off = 1'b1;
    cyc(4);
    check(gate, 1'b0, "gate off dcm");
    turn_off = 1'b0;
    cur_surge = 1'b1;
    cyc(3000);
    check(gate, 1'b0, "gate surge");
    cur_surge = 1'b0;
    for (k = 0; k < 4; k = k + 1)
    begin
      {is_5v, div_gnd} = k;
      cyc(5);
      check(comp, k == 3, "compensation");
    end
    cur_thr = 1'b1;
    cyc(5);
    check(cur_mode, 1'b1, "current mode on");
    cur_thr = 1'b0;
    cyc(5);
    check(cur_mode, 1'b0, "current mode off");
    {cur_thr, floor_low} = 2'h3;
    cyc(20);
    check(restart, 1'b1, "floor restart");
    {cur_thr, floor_low} = 2'h0;
    wait_for(2, 30000);
    fb_low = 1'b1;
    cyc(70);
    check({in_ctl, restart}, 2'h1, "low output");
    fb_low = 1'b0;
    wait_for(2, 30000);
    fb_short = 1'b1;
    cyc(1000);
    check(restart, 1'b1, "short restart");
    cyc(5000);
    check(in_ctl, 1'b0, "short control");
    fb_short = 1'b0;
    wait_for(2, 30000);
    silent = 1'b1;
    cyc(5000);
    check(in_ctl, 1'b0, "silent primary");
    silent = 1'b0;
    wait_for(2, 30000);
    print_verdict;
  end
endmodule

// File: verif/primary_switch_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Primary side switch controller
// ----------------------------------------
module primary_switch_model #(
  parameter ON_CYC = 20
) (
  input wire ref_clk,
  input wire cycle_request,
  input wire silent,
  output reg primary_switched,
  output reg primary_cycle_done,
  output reg winding_falling
);
  integer cnt;
  initial
  begin
    cnt = 0;
    primary_switched = 1'b0;
    primary_cycle_done = 1'b0;
    winding_falling = 1'b0;
  end
  // Silent mode stands for a primary that stopped answering.
  always @(negedge ref_clk)
  begin
    primary_switched <= 1'b0;
    primary_cycle_done <= 1'b0;
    winding_falling <= 1'b0;
    if (cnt == 0 && cycle_request && !silent)
    begin
      cnt = 1;
      primary_switched <= 1'b1;
    end
    else if (cnt > 0)
    begin
      cnt = cnt + 1;
      if (cnt == ON_CYC)
      begin
        cnt = 0;
        primary_cycle_done <= 1'b1;
        winding_falling <= 1'b1;
      end
    end
  end
endmodule
